// [hdl/dal_top.sv]
// Overview of operation
// - Enable bit gates alarm, keeps parameters.
// - Setpoints accepted only within calibrated range.
// - Each alarm selects high or low.
// - Output open or closed idle, inverts active.
// - Loop power lost opens both outputs.
// - Hysteresis in displayed engineering units.
// - High sets at setpoint, clears below minus band.
// - Activation wait 0 to 3600 seconds.
// - Wait must hold unbroken, break restarts.
// - Annunciator flashes waiting, steady when active.
// - Nonzero mute period makes select accept.
// - Accept mutes output, reactivates after period.
// - Annunciator flashes while muted.
// - Alternate display cycles tags of active alarms.
// - No alternating during wait or mute.
// - Select plus up opens setpoint menu.
// - Menu disabled means no setpoint access.
// - Four digit pin, zero skips check.
// - Reset: menu off, pin zero.
// - Wrong pin or twenty seconds idle exits.
// - Compare against displayed value with tare.
//
// The plain strobed port and the register offsets were left to the implementer.
`timescale 1ns/1ps
`default_nettype none
`include "dal_cfg.svh"

module dal_top
  import dal_pkg::*;
#(
  parameter int TICK_CYCLES = `DAL_CLK_HZ * `DAL_TICK_S
)
(
  // Clock and reset.
  input wire logic clk,
  input wire logic rst,
  // Process value and calibration limits.
  input wire logic [`DAL_VAL_W-1:0] display_value,
  input wire logic [`DAL_VAL_W-1:0] range_min,
  input wire logic [`DAL_VAL_W-1:0] range_max,
  input wire logic loop_power_ok,
  // Push buttons, level, high while pressed.
  input wire logic btn_select,
  input wire logic btn_up,
  input wire logic btn_down,
  input wire logic btn_return,
  // Register port.
  input wire logic [7:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_write,
  input wire logic reg_read,
  output logic [31:0] reg_rdata,
  // Switched outputs and display.
  output logic [1:0] alarm_closed,
  output logic [1:0] annunciator,
  output logic [1:0] display_tag,
  output logic [1:0] menu_state,
  output logic [2:0] menu_digit,
  output logic [`DAL_VAL_W-1:0] menu_value
);

  localparam logic [`DAL_TICK_W-1:0] TICK_LAST = `DAL_TICK_W'(TICK_CYCLES - 1);
  localparam logic [2:0] RST_CTRL = `DAL_RST_CTRL;

  dal_state_t s;
  dal_state_t next_s;

  // ==========================================================
  // Helper functions.
  function automatic logic in_range(input logic [`DAL_VAL_W-1:0] v,
                                    input logic [`DAL_VAL_W-1:0] lo,
                                    input logic [`DAL_VAL_W-1:0] hi);
    in_range = ($signed(v) >= $signed(lo)) && ($signed(v) <= $signed(hi));
  endfunction

  function automatic logic alarm_cond(input logic [`DAL_VAL_W-1:0] v,
                                      input logic [`DAL_VAL_W-1:0] sp,
                                      input logic [`DAL_VAL_W-1:0] hy,
                                      input logic high,
                                      input logic prev);
    logic signed [`DAL_VAL_W:0] vx;
    logic signed [`DAL_VAL_W:0] spx;
    logic signed [`DAL_VAL_W:0] hyx;
    vx = {v[`DAL_VAL_W-1], v};
    spx = {sp[`DAL_VAL_W-1], sp};
    hyx = {1'b0, hy};
    if (high)
    begin
      alarm_cond = prev ? (vx >= spx - hyx) : (vx >= spx);
    end
    else
    begin
      alarm_cond = prev ? (vx <= spx + hyx) : (vx <= spx);
    end
  endfunction

  function automatic logic [`DAL_VAL_W-1:0] digit_weight(input logic [2:0] p);
    case (p)
      3'h0: digit_weight = `DAL_VAL_W'h00001;
      3'h1: digit_weight = `DAL_VAL_W'h0000a;
      3'h2: digit_weight = `DAL_VAL_W'h00064;
      3'h3: digit_weight = `DAL_VAL_W'h003e8;
      default: digit_weight = `DAL_VAL_W'h02710;
    endcase
  endfunction

  function automatic logic [7:0] alarm_field(input logic [7:0] a);
    alarm_field = (a >= `DAL_ALM_STRIDE) ? (a - `DAL_ALM_STRIDE) : a;
  endfunction

  function automatic logic [12:0] clip_sec(input logic [31:0] d);
    clip_sec = {d[31:12] == 20'h00000 && d[11:0] <= `DAL_SEC_MAX, d[11:0]};
  endfunction

  // ==========================================================
  // Next state.
  always_comb
  begin
    logic [3:0] btn;
    logic [3:0] rise;
    logic tick;
    logic accept;
    logic [1:0] act;
    logic [3:0] dig;
    logic [7:0] fld;
    logic idx;
    logic [12:0] sec;
    btn = 4'h0;
    rise = 4'h0;
    tick = 1'b0;
    accept = 1'b0;
    act = 2'h0;
    dig = 4'h0;
    fld = 8'h00;
    idx = 1'b0;
    sec = 13'h0000;
    next_s = s;

    btn[`DAL_BTN_SEL] = btn_select;
    btn[`DAL_BTN_UP] = btn_up;
    btn[`DAL_BTN_DOWN] = btn_down;
    btn[`DAL_BTN_RET] = btn_return;
    rise = btn & ~s.btn_prev;
    next_s.btn_prev = btn;

    // One second tick and blink phase.
    next_s.tick_p = 1'b0;
    if (s.tick_cnt == TICK_LAST)
    begin
      next_s.tick_cnt = '0;
      next_s.tick_p = 1'b1;
      next_s.blink = ~s.blink;
    end
    else
    begin
      next_s.tick_cnt = s.tick_cnt + 1'b1;
    end
    tick = s.tick_p;

    accept = rise[`DAL_BTN_SEL] && !btn[`DAL_BTN_UP] && (s.menu == MENU_DISPLAY);

    // Alarm channels.
    for (int i = 0; i < 2; i++)
    begin
      next_s.cond[i] = alarm_cond(display_value, s.sp[i], s.hyst[i], s.dir_high[i], s.cond[i]);
      if (!s.en[i])
      begin
        next_s.phase[i] = PH_IDLE;
      end
      else
      begin
        case (s.phase[i])
          PH_IDLE:
          begin
            next_s.cnt[i] = '0;
            if (s.cond[i])
            begin
              next_s.phase[i] = (s.wait_s[i] == '0) ? PH_ACTIVE : PH_WAITING;
            end
          end
          PH_WAITING:
          begin
            if (!s.cond[i])
            begin
              next_s.phase[i] = PH_IDLE;
            end
            else if (tick)
            begin
              next_s.cnt[i] = s.cnt[i] + 1'b1;
              if (s.cnt[i] + 1'b1 >= s.wait_s[i])
              begin
                next_s.phase[i] = PH_ACTIVE;
              end
            end
          end
          PH_ACTIVE:
          begin
            next_s.cnt[i] = '0;
            if (!s.cond[i])
            begin
              next_s.phase[i] = PH_IDLE;
            end
            else if (accept && s.mute_s[i] != '0)
            begin
              next_s.phase[i] = PH_MUTED;
            end
          end
          PH_MUTED:
          begin
            if (!s.cond[i])
            begin
              next_s.phase[i] = PH_IDLE;
            end
            else if (tick)
            begin
              next_s.cnt[i] = s.cnt[i] + 1'b1;
              if (s.cnt[i] + 1'b1 >= s.mute_s[i])
              begin
                next_s.phase[i] = PH_ACTIVE;
              end
            end
          end
          default: next_s.phase[i] = PH_IDLE;
        endcase
      end
      act[i] = (s.phase[i] == PH_ACTIVE);
      next_s.out_closed[i] = loop_power_ok && (s.closed_idle[i] ^ act[i]);
      next_s.ann[i] = act[i] || (((s.phase[i] == PH_WAITING) || (s.phase[i] == PH_MUTED)) && s.blink);
    end

    // Alternate display sequence.
    if (!s.alt_on || act == 2'h0)
    begin
      next_s.show = 2'h0;
    end
    else if (tick)
    begin
      case (s.show)
        2'h0: next_s.show = act[0] ? 2'h1 : 2'h2;
        2'h1: next_s.show = act[1] ? 2'h2 : 2'h0;
        default: next_s.show = 2'h0;
      endcase
    end
    else if ((s.show == 2'h1 && !act[0]) || (s.show == 2'h2 && !act[1]))
    begin
      next_s.show = 2'h0;
    end

    // Direct setpoint menu.
    if (rise != 4'h0)
    begin
      next_s.idle_s = '0;
    end
    else if (tick && s.menu != MENU_DISPLAY)
    begin
      next_s.idle_s = s.idle_s + 1'b1;
    end
    if (s.menu != MENU_DISPLAY && s.idle_s >= `DAL_MENU_TIMEOUT_S)
    begin
      next_s.menu = MENU_DISPLAY;
    end
    else
    begin
      case (s.menu)
        MENU_DISPLAY:
        begin
          next_s.idle_s = '0;
          if (s.menu_on && btn[`DAL_BTN_SEL] && btn[`DAL_BTN_UP] && (rise[`DAL_BTN_SEL] || rise[`DAL_BTN_UP]))
          begin
            next_s.menu = (s.pin == 16'h0000) ? MENU_SELECT : MENU_CODE;
            next_s.code = 16'h0000;
            next_s.pos = 3'h0;
            next_s.sel_sp = 1'b0;
          end
        end
        MENU_CODE:
        begin
          dig = s.code[s.pos[1:0]*4 +: 4];
          if (rise[`DAL_BTN_UP])
          begin
            next_s.code[s.pos[1:0]*4 +: 4] = (dig == 4'h9) ? 4'h0 : dig + 4'h1;
          end
          else if (rise[`DAL_BTN_DOWN])
          begin
            next_s.code[s.pos[1:0]*4 +: 4] = (dig == 4'h0) ? 4'h9 : dig - 4'h1;
          end
          else if (rise[`DAL_BTN_SEL])
          begin
            next_s.pos = {1'b0, s.pos[1:0] + 2'h1};
          end
          else if (rise[`DAL_BTN_RET])
          begin
            next_s.menu = (s.code == s.pin) ? MENU_SELECT : MENU_DISPLAY;
          end
        end
        MENU_SELECT:
        begin
          if (rise[`DAL_BTN_UP] || rise[`DAL_BTN_DOWN])
          begin
            next_s.sel_sp = ~s.sel_sp;
          end
          else if (rise[`DAL_BTN_SEL])
          begin
            next_s.menu = MENU_EDIT;
            next_s.pos = 3'h0;
            next_s.edit_val = s.sp[s.sel_sp];
          end
          else if (rise[`DAL_BTN_RET])
          begin
            next_s.menu = MENU_DISPLAY;
          end
        end
        MENU_EDIT:
        begin
          if (rise[`DAL_BTN_UP])
          begin
            next_s.edit_val = s.edit_val + digit_weight(s.pos);
          end
          else if (rise[`DAL_BTN_DOWN])
          begin
            next_s.edit_val = s.edit_val - digit_weight(s.pos);
          end
          else if (rise[`DAL_BTN_SEL])
          begin
            next_s.pos = (s.pos == 3'h4) ? 3'h0 : s.pos + 3'h1;
          end
          else if (rise[`DAL_BTN_RET])
          begin
            if (in_range(s.edit_val, range_min, range_max))
            begin
              next_s.sp[s.sel_sp] = s.edit_val;
            end
            next_s.menu = MENU_SELECT;
          end
        end
        default: next_s.menu = MENU_DISPLAY;
      endcase
    end

    // Register writes.
    fld = alarm_field(reg_addr);
    idx = (reg_addr >= `DAL_ALM_STRIDE);
    sec = clip_sec(reg_wdata);
    if (reg_write)
    begin
      if (reg_addr < `DAL_REG_LIMIT)
      begin
        case (fld)
          `DAL_REG_CTRL:
          begin
            next_s.en[idx] = reg_wdata[`DAL_CTRL_EN];
            next_s.dir_high[idx] = reg_wdata[`DAL_CTRL_HIGH];
            next_s.closed_idle[idx] = reg_wdata[`DAL_CTRL_CLOSED];
          end
          `DAL_REG_SETPOINT:
          begin
            if (in_range(reg_wdata[`DAL_VAL_W-1:0], range_min, range_max))
            begin
              next_s.sp[idx] = reg_wdata[`DAL_VAL_W-1:0];
            end
          end
          `DAL_REG_HYST: next_s.hyst[idx] = reg_wdata[`DAL_VAL_W-1:0];
          `DAL_REG_WAIT:
          begin
            if (sec[12])
            begin
              next_s.wait_s[idx] = sec[11:0];
            end
          end
          `DAL_REG_MUTE:
          begin
            if (sec[12])
            begin
              next_s.mute_s[idx] = sec[11:0];
            end
          end
          default: next_s.rdata = s.rdata;
        endcase
      end
      else if (reg_addr == `DAL_REG_GLOBAL)
      begin
        next_s.alt_on = reg_wdata[`DAL_GLB_ALT];
        next_s.menu_on = reg_wdata[`DAL_GLB_MENU];
      end
      else if (reg_addr == `DAL_REG_PIN)
      begin
        next_s.pin = reg_wdata[15:0];
      end
    end

    // Register reads.
    next_s.rdata = 32'h00000000;
    if (reg_read)
    begin
      if (reg_addr < `DAL_REG_LIMIT)
      begin
        case (fld)
          `DAL_REG_CTRL: next_s.rdata = {29'h0, s.closed_idle[idx], s.dir_high[idx], s.en[idx]};
          `DAL_REG_SETPOINT: next_s.rdata = {12'h000, s.sp[idx]};
          `DAL_REG_HYST: next_s.rdata = {12'h000, s.hyst[idx]};
          `DAL_REG_WAIT: next_s.rdata = {20'h00000, s.wait_s[idx]};
          `DAL_REG_MUTE: next_s.rdata = {20'h00000, s.mute_s[idx]};
          default: next_s.rdata = 32'h00000000;
        endcase
      end
      else
      begin
        case (reg_addr)
          `DAL_REG_GLOBAL: next_s.rdata = {30'h0, s.menu_on, s.alt_on};
          `DAL_REG_PIN: next_s.rdata = {16'h0000, s.pin};
          `DAL_REG_STATUS: next_s.rdata = {18'h0, s.menu, s.show, s.ann, s.out_closed, s.cond,
                                           s.phase[1], s.phase[0]};
          default: next_s.rdata = 32'h00000000;
        endcase
      end
    end
  end

  // ==========================================================
  // State register.
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      s <= '0;
      s.en <= {2{RST_CTRL[`DAL_CTRL_EN]}};
      s.dir_high <= {2{RST_CTRL[`DAL_CTRL_HIGH]}};
      s.closed_idle <= {2{RST_CTRL[`DAL_CTRL_CLOSED]}};
      s.pin <= `DAL_RST_PIN;
      s.menu_on <= 1'b0;
      s.phase[0] <= PH_IDLE;
      s.phase[1] <= PH_IDLE;
      s.menu <= MENU_DISPLAY;
    end
    else
    begin
      s <= next_s;
    end
  end

  // ==========================================================
  // Outputs.
  assign reg_rdata = s.rdata;
  assign alarm_closed = s.out_closed;
  assign annunciator = s.ann;
  assign display_tag = s.show;
  assign menu_state = s.menu;
  assign menu_digit = s.pos;
  assign menu_value = s.edit_val;

endmodule

`default_nettype wire

// [hdl/dal_cfg.svh]
`ifndef DAL_CFG_SVH
`define DAL_CFG_SVH

// ==========================================================
// Timing.
`define DAL_CLK_HZ 100000000
`define DAL_TICK_S 1
`define DAL_TICK_W 27
`define DAL_MENU_TIMEOUT_S 5'h14
`define DAL_VAL_W 20
`define DAL_SEC_W 12
`define DAL_SEC_MAX 12'he10

// ==========================================================
// Register offsets, alarm two at alarm one plus stride.
`define DAL_ALM_STRIDE 8'h20
`define DAL_REG_CTRL 8'h00
`define DAL_REG_SETPOINT 8'h04
`define DAL_REG_HYST 8'h08
`define DAL_REG_WAIT 8'h0c
`define DAL_REG_MUTE 8'h10
`define DAL_REG_GLOBAL 8'h40
`define DAL_REG_PIN 8'h44
`define DAL_REG_STATUS 8'h48
`define DAL_REG_LIMIT 8'h40

// ==========================================================
// Field positions.
`define DAL_CTRL_EN 0
`define DAL_CTRL_HIGH 1
`define DAL_CTRL_CLOSED 2
`define DAL_GLB_ALT 0
`define DAL_GLB_MENU 1
`define DAL_BTN_SEL 0
`define DAL_BTN_UP 1
`define DAL_BTN_DOWN 2
`define DAL_BTN_RET 3

// ==========================================================
// Reset values.
`define DAL_RST_PIN 16'h0000
`define DAL_RST_CTRL 3'h2

`endif

// [hdl/dal_pkg.sv]
`include "dal_cfg.svh"

package dal_pkg;

  typedef enum logic [1:0] {
    PH_IDLE,
    PH_WAITING,
    PH_ACTIVE,
    PH_MUTED
  } dal_phase_t;

  typedef enum logic [1:0] {
    MENU_DISPLAY,
    MENU_CODE,
    MENU_SELECT,
    MENU_EDIT
  } dal_menu_t;

  typedef struct packed {
    logic [1:0] en;
    logic [1:0] dir_high;
    logic [1:0] closed_idle;
    logic [1:0][`DAL_VAL_W-1:0] sp;
    logic [1:0][`DAL_VAL_W-1:0] hyst;
    logic [1:0][`DAL_SEC_W-1:0] wait_s;
    logic [1:0][`DAL_SEC_W-1:0] mute_s;
    logic [1:0][`DAL_SEC_W-1:0] cnt;
    logic [1:0] cond;
    dal_phase_t [1:0] phase;
    logic alt_on;
    logic menu_on;
    logic [15:0] pin;
    logic [`DAL_TICK_W-1:0] tick_cnt;
    logic tick_p;
    logic blink;
    logic [1:0] show;
    dal_menu_t menu;
    logic [4:0] idle_s;
    logic [15:0] code;
    logic [2:0] pos;
    logic sel_sp;
    logic [`DAL_VAL_W-1:0] edit_val;
    logic [3:0] btn_prev;
    logic [31:0] rdata;
    logic [1:0] out_closed;
    logic [1:0] ann;
  } dal_state_t;

endpackage

// [hdl/dal_top_unused_none.sv]
`timescale 1ns/1ps
`default_nettype none
`default_nettype wire

// [dv/dal_top_monitor.sv]
`timescale 1ns/1ps
`default_nettype none
`include "dal_cfg.svh"

// ==========
// Port checker.
module dal_top_monitor
  import dal_pkg::*;
#(
  parameter int TICK_CYCLES = 10
)
(
  // Clock and reset.
  input wire logic clk,
  input wire logic rst,
  // Inputs watched.
  input wire logic loop_power_ok,
  input wire logic btn_select,
  input wire logic btn_up,
  input wire logic btn_down,
  input wire logic btn_return,
  input wire logic [7:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_write,
  // Outputs checked.
  input wire logic [1:0] alarm_closed,
  input wire logic [1:0] annunciator,
  input wire logic [1:0] display_tag,
  input wire logic [1:0] menu_state
);
  wire logic [3:0] btn_now;
  logic [3:0] btn_q;
  logic pwr_q;
  logic [3:0] cfg;
  logic [2:0] quiet;
  int idle_cnt;
  assign btn_now = {btn_return, btn_down, btn_up, btn_select};
  // Shadow of alarm one enable and idle level, alternate and menu bits; quiet counts cycles since the last register write or loop power change.
  always_ff @(posedge clk)
  begin
    btn_q <= btn_now;
    pwr_q <= loop_power_ok;
    if (rst)
    begin
      cfg <= 4'h0;
      quiet <= 3'h0;
      idle_cnt <= 0;
    end
    else
    begin
      if (reg_write && reg_addr == `DAL_REG_CTRL)
      begin
        cfg[1:0] <= {reg_wdata[`DAL_CTRL_CLOSED], reg_wdata[`DAL_CTRL_EN]};
      end
      if (reg_write && reg_addr == `DAL_REG_GLOBAL)
      begin
        cfg[3:2] <= {reg_wdata[`DAL_GLB_MENU], reg_wdata[`DAL_GLB_ALT]};
      end
      quiet <= (reg_write || pwr_q != loop_power_ok) ? 3'h0 : quiet + {2'h0, quiet != 3'h7};
      idle_cnt <= (menu_state == 2'h0 || (btn_now & ~btn_q) != 4'h0) ? 0 : idle_cnt + 1;
    end
  end
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);
  reset_out_a: assert property ($past(rst) |-> alarm_closed == 2'h0 && menu_state == 2'h0)
    else $error("outputs not idle after reset");
  power_loss_a: assert property (!loop_power_ok [*3] |-> alarm_closed == 2'h0)
    else $error("switch closed without loop power");
  idle_level_a: assert property (quiet >= 3'h3 && !cfg[0] |-> alarm_closed[0] == (cfg[1] && loop_power_ok))
    else $error("disabled alarm not at idle level");
  ann_steady_a: assert property (quiet >= 3'h3 && loop_power_ok && cfg[0] && alarm_closed[0] != cfg[1] |-> annunciator[0])
    else $error("active output without steady annunciator");
  menu_off_a: assert property (quiet >= 3'h2 && !cfg[3] && $past(menu_state) == 2'h0 |-> menu_state == 2'h0)
    else $error("menu opened while disabled");
  tag_alt_a: assert property (quiet >= 3'h3 && !cfg[2] |-> display_tag == 2'h0)
    else $error("tag shown with alternate display off");
  tag_code_a: assert property (display_tag != 2'h3)
    else $error("illegal tag code");
  menu_timeout_a: assert property (idle_cnt <= 21 * TICK_CYCLES + 8)
    else $error("menu idle too long");
endmodule

bind dal_top dal_top_monitor #(.TICK_CYCLES(TICK_CYCLES)) i_dal_top_monitor (.clk, .rst, .loop_power_ok,
  .btn_select, .btn_up, .btn_down, .btn_return, .reg_addr, .reg_wdata, .reg_write, .alarm_closed,
  .annunciator, .display_tag, .menu_state);
`default_nettype wire

// [dv/dal_operator.sv]
`timescale 1ns/1ps
`default_nettype none

// ==========
// Operator keys and field circuits.
module dal_operator
(
  // Clock.
  input wire logic clk,
  // Switch states.
  input wire logic [1:0] alarm_closed,
  // Push buttons.
  output wire logic btn_select,
  output wire logic btn_up,
  output wire logic btn_down,
  output wire logic btn_return,
  // Field circuit current.
  output wire logic [1:0] load_on
);
  logic [3:0] held = 4'h0;
  assign {btn_return, btn_down, btn_up, btn_select} = held;
  assign load_on = alarm_closed;
  // One key or chord is held, then all keys are let go before the next.
  task automatic press(input logic [3:0] keys);
    @(posedge clk);
    held <= keys;
    repeat (3) @(posedge clk);
    held <= 4'h0;
    repeat (2) @(posedge clk);
    #1;
  endtask
endmodule
`default_nettype wire

// [dv/tb.sv]
`timescale 1ns/1ps
`default_nettype none

// ==========
// Testbench.
module tb;
  localparam int TICK = 10;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic [19:0] dv = 20'h00000;
  logic [19:0] rmin = 20'hfff83;
  logic [19:0] rmax = 20'h0278d;
  logic pwr = 1'b1;
  logic [7:0] addr = 8'h00;
  logic [31:0] wd = 32'h0;
  logic wr_s = 1'b0;
  logic rd_s = 1'b0;
  wire logic [31:0] rdata;
  wire logic [1:0] closed, ann, tag, mstate, load;
  wire logic [2:0] mdig;
  wire logic [19:0] mval;
  wire logic b_sel, b_up, b_dn, b_ret;
  logic [1:0] seen;
  int n_mismatch = 0;
  int check_count = 0;
  int n;
  always #5 clk = ~clk;
  dal_top #(.TICK_CYCLES(TICK)) i_dal_top (.clk(clk), .rst(rst), .display_value(dv), .range_min(rmin),
    .range_max(rmax), .loop_power_ok(pwr), .btn_select(b_sel), .btn_up(b_up), .btn_down(b_dn),
    .btn_return(b_ret), .reg_addr(addr), .reg_wdata(wd), .reg_write(wr_s), .reg_read(rd_s), .reg_rdata(rdata),
    .alarm_closed(closed), .annunciator(ann), .display_tag(tag), .menu_state(mstate), .menu_digit(mdig),
    .menu_value(mval));
  dal_operator i_dal_operator (.clk(clk), .alarm_closed(closed), .btn_select(b_sel), .btn_up(b_up),
    .btn_down(b_dn), .btn_return(b_ret), .load_on(load));
  task automatic chk_reg(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp)
    begin
      n_mismatch++;
      $display("Error at %0t: word %h, expected %h", $time, got, exp);
    end
  endtask
  task automatic chk_pin(input logic [1:0] got, input logic [1:0] exp);
    check_count++;
    if (got !== exp)
    begin
      n_mismatch++;
      $display("Error at %0t: output %h, expected %h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    addr <= a;
    wd <= d;
    wr_s <= 1'b1;
    @(posedge clk);
    wr_s <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] exp, input logic [31:0] m = 32'hffffffff);
    @(posedge clk);
    addr <= a;
    rd_s <= 1'b1;
    @(posedge clk);
    rd_s <= 1'b0;
    #1;
    chk_reg(rdata & m, exp);
  endtask
  task automatic setv(input logic [19:0] v);
    @(posedge clk);
    dv <= v;
    repeat (4) @(posedge clk);
    #1;
  endtask
  function automatic logic [1:0] pick(input int sel);
    case (sel)
      0: pick = {1'b0, closed[0]};
      1: pick = tag;
      default: pick = mstate;
    endcase
  endfunction
  task automatic wait_for(input int sel, input logic [1:0] val, input int lim);
    n = 0;
    while (pick(sel) !== val && n < lim)
    begin
      @(posedge clk);
      #1;
      n++;
      if (n >= 4)
      begin
        seen[ann[0]] = 1'b1;
      end
    end
    chk_pin(pick(sel), val);
  endtask
  task automatic final_report;
    if (n_mismatch == 0 && check_count > 0)
    begin
      $display("NO MISMATCHES");
    end
    else
    begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask
  initial
  begin
    #100000;
    n_mismatch++;
    final_report;
  end
  initial
  begin
    repeat (8) @(posedge clk);
    rst <= 1'b0;
    rd(8'h00, 32'h2);
    rd(8'h20, 32'h2);
    rd(8'h40, 32'h0);
    rd(8'h44, 32'h0);
    rd(8'h48, 32'h30);
    rd(8'h14, 32'h0);
    wr(8'h04, 32'h278e);
    rd(8'h04, 32'h0);
    wr(8'h04, 32'hfff82);
    rd(8'h04, 32'h0);
    wr(8'h04, 32'hfff83);
    rd(8'h04, 32'hfff83);
    @(posedge clk);
    rmin <= 20'hfff9c;
    rmax <= 20'h02710;
    wr(8'h04, 32'hfff9b);
    rd(8'h04, 32'hfff83);
    wr(8'h04, 32'h2711);
    rd(8'h04, 32'hfff83);
    wr(8'h04, 32'h2710);
    rd(8'h04, 32'h2710);
    wr(8'h04, 32'h2328);
    wr(8'h08, 32'hc8);
    wr(8'h00, 32'h3);
    setv(20'h02327);
    chk_pin(closed, 2'h0);
    setv(20'h02328);
    chk_pin(closed, 2'h1);
    chk_pin(ann, 2'h1);
    setv(20'h02260);
    chk_pin(closed, 2'h1);
    setv(20'h0225f);
    chk_pin(closed, 2'h0);
    wr(8'h00, 32'h7);
    wr(8'h20, 32'h5);
    setv(20'h0225f);
    chk_pin(load, 2'h3);
    setv(20'h02328);
    chk_pin(load, 2'h2);
    @(posedge clk);
    pwr <= 1'b0;
    setv(20'h02328);
    chk_pin(load, 2'h0);
    @(posedge clk);
    pwr <= 1'b1;
    wr(8'h00, 32'h6);
    setv(20'h02328);
    chk_pin(closed, 2'h3);
    rd(8'h04, 32'h2328);
    rd(8'h08, 32'hc8);
    wr(8'h24, 32'h64);
    wr(8'h28, 32'h32);
    wr(8'h20, 32'h1);
    setv(20'h00064);
    chk_pin(closed, 2'h3);
    setv(20'h00096);
    chk_pin(closed, 2'h3);
    setv(20'h00097);
    chk_pin(closed, 2'h1);
    wr(8'h00, 32'h3);
    wr(8'h0c, 32'he11);
    rd(8'h0c, 32'h0);
    wr(8'h0c, 32'h3);
    rd(8'h0c, 32'h3);
    setv(20'h02328);
    rd(8'h48, 32'h1, 32'h3);
    repeat (8) @(posedge clk);
    setv(20'h00000);
    @(posedge clk);
    dv <= 20'h02328;
    seen = 2'h0;
    wait_for(0, 2'h1, 60);
    chk_pin({1'b0, n >= 18 && n <= 36}, 2'h1);
    chk_pin(seen, 2'h3);
    wr(8'h0c, 32'h0);
    i_dal_operator.press(4'h1);
    chk_pin(closed, 2'h1);
    wr(8'h40, 32'h1);
    wr(8'h10, 32'h2);
    i_dal_operator.press(4'h1);
    chk_pin(closed, 2'h0);
    rd(8'h48, 32'h3, 32'hf);
    chk_pin(tag, 2'h0);
    wait_for(0, 2'h1, 40);
    chk_pin({1'b0, n >= 3}, 2'h1);
    wait_for(1, 2'h1, 40);
    wr(8'h24, 32'h251c);
    wait_for(1, 2'h2, 60);
    wr(8'h40, 32'h0);
    i_dal_operator.press(4'h3);
    chk_pin(mstate, 2'h0);
    wr(8'h40, 32'h2);
    i_dal_operator.press(4'h3);
    chk_pin(mstate, 2'h2);
    i_dal_operator.press(4'h1);
    chk_pin(mstate, 2'h3);
    chk_reg({12'h0, mval}, 32'h2328);
    chk_reg({29'h0, mdig}, 32'h0);
    i_dal_operator.press(4'h2);
    chk_reg({12'h0, mval}, 32'h2329);
    i_dal_operator.press(4'h1);
    chk_reg({29'h0, mdig}, 32'h1);
    i_dal_operator.press(4'h2);
    chk_reg({12'h0, mval}, 32'h2333);
    i_dal_operator.press(4'h8);
    chk_pin(mstate, 2'h2);
    rd(8'h04, 32'h2333);
    wait_for(2, 2'h0, 300);
    chk_pin({1'b0, n >= 180}, 2'h1);
    wr(8'h44, 32'h1);
    i_dal_operator.press(4'h3);
    chk_pin(mstate, 2'h1);
    i_dal_operator.press(4'h8);
    chk_pin(mstate, 2'h0);
    i_dal_operator.press(4'h3);
    chk_pin(mstate, 2'h1);
    i_dal_operator.press(4'h2);
    i_dal_operator.press(4'h8);
    chk_pin(mstate, 2'h2);
    final_report;
  end
endmodule
`default_nettype wire
